/* frac_dec_regs.vh */
// constants for the fractional decimator rate controller
`ifndef FRAC_DEC_REGS_VH
`define FRAC_DEC_REGS_VH

// =====================================================================
// datapath geometry
`define DATA_W 16
`define LANES 2
`define PATHS 2
`define BEAT_W 64
`define ACC_W 48
`define OUT_W 24
`define OUT_BUS_W 48

// =====================================================================
// configuration widths
`define PER_W 12
`define RATE_W 4
`define TOT_W 5
`define CHL_W 2
`define CH_W 2

// =====================================================================
// input fifo
`define FIFO_DEPTH 8
`define FIFO_AW 3

// =====================================================================
// state codes, one-hot
`define ST_PLAN 3'h1
`define ST_GATHER 3'h2
`define ST_WAIT 3'h4

// =====================================================================
// reset values
`define PER_RST 12'h000
`define ZERO_ACC 48'h000000000000

`endif

/* sample_fifo.v */
// stream fifo with registered input ready
module sample_fifo #(
	parameter W = 64,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk,
	input wire rst_n,
	input wire in_valid,
	output reg in_ready,
	input wire [W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	reg [AW:0] cnt_d;
	wire push;
	wire pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data = mem[rd_q];

	always @* begin
		cnt_d = cnt_q;
		if (push && !pop)
			cnt_d = cnt_q + 1'b1;
		else if (pop && !push)
			cnt_d = cnt_q - 1'b1;
	end

	always @(posedge clk) begin
		if (push)
			mem[wr_q] <= in_data;
	end

	// ready is a flop so the upstream sees a clean level
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
			in_ready <= 1'b0;
		end else begin
			if (push)
				wr_q <= (wr_q == DEPTH - 1) ? {AW{1'b0}} : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == DEPTH - 1) ? {AW{1'b0}} : rd_q + 1'b1;
			cnt_q <= cnt_d;
			in_ready <= (cnt_d < DEPTH);
		end
	end
endmodule

/* frac_dec_ctrl.v */
// sample pacing for a fractional decimating filter core
`include "frac_dec_regs.vh"

module frac_dec_ctrl (
	input wire REF_CLK,
	input wire RSTN,
	input wire [`PER_W-1:0] OUT_PERIOD,
	input wire [`RATE_W-1:0] DEC_NUM,
	input wire [`RATE_W-1:0] DEC_DEN,
	input wire [`CHL_W-1:0] CHAN_LOG2,
	input wire S_VALID,
	output wire S_READY,
	input wire [`BEAT_W-1:0] S_DATA,
	output reg M_VALID,
	output reg [`OUT_BUS_W-1:0] M_DATA,
	output reg [`CH_W-1:0] M_CHAN
);
	// =================================================================
	// sequencer states, one-hot
	localparam [2:0] st_plan = `ST_PLAN;
	localparam [2:0] st_gather = `ST_GATHER;
	localparam [2:0] st_wait = `ST_WAIT;
	// enough passes for the largest need a 4-bit rate pair can give
	localparam integer div_steps = 1 << `RATE_W;

	// =================================================================
	// state and registers
	reg [2:0] state_q;
	reg [`RATE_W-1:0] phase_q;
	reg [`TOT_W-1:0] need_q;
	reg [`PER_W-1:0] per_cnt_q;
	reg [`CH_W-1:0] chan_q;
	reg [`ACC_W-1:0] acc_q [0:`PATHS-1];

	wire fifo_valid;
	wire [`BEAT_W-1:0] fifo_data;
	wire pop;
	wire tick;
	wire [`PER_W-1:0] budget;
	wire emit;
	wire need_done;
	wire chan_last;

	reg [`TOT_W-1:0] need_d;
	reg [`TOT_W-1:0] rem_d;
	reg [`RATE_W-1:0] den_safe;
	integer i;

	// =================================================================
	// input buffer
	// the fifo lets upstream burst at full rate; ready is its not-full
	sample_fifo #(
		.W(`BEAT_W),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_fifo (
		.clk(REF_CLK),
		.rst_n(RSTN),
		.in_valid(S_VALID),
		.in_ready(S_READY),
		.in_data(S_DATA),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(fifo_data)
	);

	// =================================================================
	// output period tick
	// channels share the period, so each gets period >> log2(channels)
	assign budget = OUT_PERIOD >> CHAN_LOG2;

	// tick free runs, so outputs stay on the period grid whatever the input timing
	assign tick = (per_cnt_q == `PER_RST);

	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN)
			per_cnt_q <= `PER_RST;
		else if (tick)
			// a zero budget is treated as one cycle
			per_cnt_q <= (budget == `PER_RST) ? `PER_RST :
				budget - 1'b1;
		else
			per_cnt_q <= per_cnt_q - 1'b1;
	end

	// =================================================================
	// rate pattern: beats needed for the next output position
	// each beat carries one sample time on all lanes, so the pattern
	// counts beats; DEC_NUM outputs per DEC_DEN inputs
	always @* begin
		den_safe = DEC_NUM;
		if (DEC_NUM == {`RATE_W{1'b0}})
			den_safe = {{(`RATE_W-1){1'b0}}, 1'b1};
		rem_d = {1'b0, phase_q} + {1'b0, DEC_DEN};
		need_d = {`TOT_W{1'b0}};
		// bounded repeated subtraction instead of a divider
		for (i = 0; i < div_steps; i = i + 1) begin
			if (rem_d >= {1'b0, den_safe}) begin
				rem_d = rem_d - {1'b0, den_safe};
				need_d = need_d + 1'b1;
			end
		end
	end

	// =================================================================
	// sequencer
	// draws beats only while the current position still needs them
	assign pop = (state_q == st_gather) && fifo_valid &&
		(need_q != {`TOT_W{1'b0}});

	// the last pop and the move to wait share one edge
	assign need_done = (need_q == {`TOT_W{1'b0}}) ||
		(pop && need_q == {{(`TOT_W-1){1'b0}}, 1'b1});

	// upstream interleaves channels in output order; wrap at 2**log2 - 1
	assign chan_last = (chan_q ==
		(({`CH_W{1'b0}} + 1'b1) << CHAN_LOG2) - 1'b1);

	// output instant: a tick that finds the position complete
	assign emit = (state_q == st_wait) && tick;

	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_q <= st_plan;
			phase_q <= {`RATE_W{1'b0}};
			need_q <= {`TOT_W{1'b0}};
			chan_q <= {`CH_W{1'b0}};
		end else begin
			case (state_q)
			st_plan: begin
				need_q <= need_d;
				phase_q <= rem_d[`RATE_W-1:0];
				state_q <= st_gather;
			end
			st_gather: begin
				if (pop)
					need_q <= need_q - 1'b1;
				if (need_done)
					state_q <= st_wait;
			end
			st_wait: begin
				if (tick) begin
					state_q <= st_plan;
					if (chan_last)
						chan_q <= {`CH_W{1'b0}};
					else
						chan_q <= chan_q + 1'b1;
				end
			end
			default: begin
				state_q <= st_plan;
			end
			endcase
		end
	end

	// =================================================================
	// per-path accumulators with shared control
	genvar p;
	generate
		for (p = 0; p < `PATHS; p = p + 1) begin : g_path
			reg [`ACC_W-1:0] beat_sum;
			integer l;
			// the path's own two lanes of one beat fold into it; the output
			// lane count is the input lanes divided by LANES, not the decimation
			always @* begin
				beat_sum = `ZERO_ACC;
				for (l = 0; l < `LANES; l = l + 1)
					beat_sum = beat_sum + {{(`ACC_W-`DATA_W){fifo_data[
						(p*`LANES+l)*`DATA_W+`DATA_W-1]}},
						fifo_data[(p*`LANES+l)*`DATA_W +: `DATA_W]};
			end

			// 48 bits covers 15 beats of two 16-bit lanes with huge
			// headroom, so no overflow path is needed
			always @(posedge REF_CLK or negedge RSTN) begin
				if (!RSTN)
					acc_q[p] <= `ZERO_ACC;
				else if (emit)
					acc_q[p] <= `ZERO_ACC;
				else if (pop)
					acc_q[p] <= acc_q[p] + beat_sum;
			end

			always @(posedge REF_CLK or negedge RSTN) begin
				if (!RSTN)
					M_DATA[p*`OUT_W +: `OUT_W] <= {`OUT_W{1'b0}};
				else if (emit)
					// low bits kept; caller scales the gain by design
					M_DATA[p*`OUT_W +: `OUT_W] <= acc_q[p][`OUT_W-1:0];
			end
		end
	endgenerate

	// =================================================================
	// output strobe
	// a tick with inputs still missing is skipped, keeping the grid
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			M_VALID <= 1'b0;
			M_CHAN <= {`CH_W{1'b0}};
		end else begin
			M_VALID <= emit;
			if (emit)
				M_CHAN <= chan_q;
		end
	end
endmodule

/* fdc_chk_sva.sv */
// port assertions for the fractional decimator rate controller
module fdc_chk (
	input wire REF_CLK,
	input wire RSTN,
	input wire [11:0] OUT_PERIOD,
	input wire [3:0] DEC_NUM,
	input wire [3:0] DEC_DEN,
	input wire [1:0] CHAN_LOG2,
	input wire S_VALID,
	input wire S_READY,
	input wire M_VALID,
	input wire [47:0] M_DATA,
	input wire [1:0] M_CHAN
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	// ===
	// tallies since reset
	logic [15:0] nin, nout, gap;
	logic [1:0] ch;
	logic st, seen;
	wire [11:0] per = OUT_PERIOD >> CHAN_LOG2;
	wire [11:0] sp = per ? per : 12'h001;
	wire [3:0] p = DEC_NUM ? DEC_NUM : 4'h1;
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			{nin, nout, gap, ch, st, seen} <= 52'h0;
		end else begin
			st <= 1'b1;
			nin <= nin + (S_VALID && S_READY);
			gap <= M_VALID ? 16'h0001 : gap + 16'h0001;
			if (M_VALID) begin
				nout <= nout + 16'h0001;
				seen <= 1'b1;
				ch <= (ch + 2'h1) & ((2'h1 << CHAN_LOG2) - 2'h1);
			end
		end
	end
	// ===
	// checks
	chk_pulse_once: assert property (M_VALID && sp > 1 |=> !M_VALID)
		else $error("output pulse too long");
	chk_tick_grid: assert property (M_VALID && seen |-> gap % sp == 0)
		else $error("output off the period grid");
	chk_data_hold: assert property ($changed(M_DATA) |-> M_VALID)
		else $error("output data moved without pulse");
	chk_fill_ready: assert property (st && nin < 16'h0008 |-> S_READY)
		else $error("ready low before buffer full");
	chk_drop_cause: assert property ($fell(S_READY) |-> $past(S_VALID))
		else $error("ready fell without a push");
	chk_ready_keep: assert property (S_READY && !S_VALID |=> S_READY)
		else $error("ready fell while idle");
	chk_enough_in: assert property (M_VALID |->
		(nout + 1) * DEC_DEN < (nin + 1) * p)
		else $error("output before its inputs");
	chk_chan_step: assert property (M_VALID |-> M_CHAN == ch)
		else $error("channel index out of order");
	cover property (!S_READY);
	cover property (M_VALID && M_CHAN == 2'h3);
	cover property (M_VALID && gap > sp);
endmodule
bind frac_dec_ctrl fdc_chk i_chk (.*);

/* beat_src.sv */
// upstream beat source model with random gaps
module beat_src (
	input wire REF_CLK,
	input wire en,
	input wire S_READY,
	output logic S_VALID,
	output logic [63:0] S_DATA
);
	timeunit 1ns;
	timeprecision 1ns;
	int seed = 32'h4b62;
	initial S_VALID = 1'b0;
	initial S_DATA = 64'h0;
	// idle data changes every cycle so stale values never match
	always @(posedge REF_CLK) begin
		if (!S_VALID || S_READY) begin
			S_VALID <= en && ($random(seed) % 4 != 0);
			S_DATA <= {$random(seed), $random(seed)};
		end
	end
endmodule

/* frac_dec_ctrl_bench.sv */
// self-checking bench for the fractional decimator rate controller
module frac_dec_ctrl_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic REF_CLK = 0, RSTN = 0, en = 0, full = 0;
	logic [11:0] OUT_PERIOD = 12'h000;
	logic [3:0] DEC_NUM = 4'h1, DEC_DEN = 4'h1;
	logic [1:0] CHAN_LOG2 = 2'h0, ch;
	wire S_VALID, S_READY, M_VALID;
	wire [63:0] S_DATA;
	wire [47:0] M_DATA;
	wire [1:0] M_CHAN;
	int errors = 0, n_checks = 0, k, cyc = 0;
	logic [47:0] q[$];
	always #12.5 REF_CLK = ~REF_CLK;
	frac_dec_ctrl i_dut (.*);
	beat_src i_src (.*);
	// ===
	// expectations
	function automatic logic [47:0] fold(logic [63:0] d);
		fold[23:0] = 24'($signed(d[15:0])) + 24'($signed(d[31:16]));
		fold[47:24] = 24'($signed(d[47:32])) + 24'($signed(d[63:48]));
	endfunction
	function automatic int need(int n);
		return (n + 1) * DEC_DEN / DEC_NUM - n * DEC_DEN / DEC_NUM;
	endfunction
	task automatic cmp(logic [47:0] g, logic [47:0] e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %0t %h %h", $time, g, e);
		end
	endtask
	task automatic cmp_chan(logic [1:0] g, logic [1:0] e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %0t %h %h", $time, g, e);
		end
	endtask
	task automatic cmp_flag(logic g);
		n_checks++;
		if (g !== 1'b1) begin
			errors++;
			$display("MISMATCH %0t %h %h", $time, g, 1'b1);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge REF_CLK) begin
		logic [47:0] s;
		if (RSTN && en && !S_READY)
			full = 1;
		if (RSTN && S_VALID && S_READY)
			q.push_back(fold(S_DATA));
		if (RSTN && M_VALID) begin
			s = 48'h0;
			repeat (need(k)) begin
				s = {s[47:24] + q[0][47:24], s[23:0] + q[0][23:0]};
				q.delete(0);
			end
			cmp(M_DATA, s);
			cmp_chan(M_CHAN, ch);
			ch = (ch + 2'h1) & ((2'h1 << CHAN_LOG2) - 2'h1);
			k++;
		end
	end
	// hang guard
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			conclude;
		end
	end
	// reset mid-run, fill while stalling, then drain
	task automatic run(int p, int qq, int per, int cl);
		@(posedge REF_CLK);
		RSTN <= 0;
		en <= 0;
		DEC_NUM <= p;
		DEC_DEN <= qq;
		OUT_PERIOD <= per;
		CHAN_LOG2 <= cl;
		repeat (10) @(posedge REF_CLK);
		k = 0;
		ch = 0;
		full = 0;
		q.delete();
		RSTN <= 1;
		@(posedge REF_CLK);
		en <= 1;
		repeat (400) @(posedge REF_CLK);
		en <= 0;
		repeat (400) @(posedge REF_CLK);
		cmp_flag(full);
		cmp_flag(k > 0 && q.size() < need(k));
		$display("test %0d/%0d period %0d done", p, qq, per);
	endtask
	initial begin
		run(3, 5, 8, 0);
		run(1, 1, 4, 0);
		run(1, 4, 12, 1);
		run(2, 3, 16, 2);
		conclude;
	end
endmodule
